// ==== core/link_autoneg.sv ====
// Link negotiation core: ability exchange, parallel detection, faults.
//
// Notes on behaviour
// - Every burst carries the content of the advertisement register.
// - While negotiating, bursts with the advertisement word replace idle pulses.
// - Partner words decoded from bursts are stored in the partner register.
// - Pick best common mode: 100 full, T4 never, 100 half, 10 full, 10 half.
// - On completion set complete bit in status and consolidated status.
// - After success enable only the chosen technology, others off.
// - With no burst answer, classify the incoming signal instead.
// - Parallel detection clears the partner capable bit.
// - Parallel detection sets partner bit 5 or 7 for detected mode.
// - Parallel detection sets complete and enables detected mode only, on the same clock edge.
// - Idle pulses only means a 10 half duplex partner.
// - Scrambled idles mean a non negotiating 100 half duplex partner.
// - A burst answer sets the partner capable bit.
// - No receive signal sets the no signal bit.
// - Several indications at once: no technology and fault bit set.
// - Partner remote fault shows in status, partner, consolidated, vendor.
// - A local fault sets advertised remote fault and sends it.
// - Link failure, restart write or enable toggle restarts negotiation.
// - Any reset returns the negotiation machine to idle.
`timescale 1ns/1ps
`default_nettype none
module link_autoneg
    import link_autoneg_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYC,
    parameter int GAP_LEN  = GAP_SLOTS,
    parameter int PD_HOLD  = PD_HOLD_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    input  wire logic        rx_flp_in,
    input  wire logic        rx_word_valid_in,
    input  wire logic [15:0] rx_word_in,
    input  wire logic        rx_nlp_in,
    input  wire logic        rx_idle100_in,
    input  wire logic        link_fail_in,
    input  wire logic        local_fault_in,
    output logic             link_pulse_out,
    output logic             flp_mode_out,
    output logic             an_complete_out,
    output logic             en_100tx_out,
    output logic             en_10t_out,
    output logic             full_duplex_out
);
    localparam int PW = $clog2(PD_HOLD + 1);

    an_state_e     state;
    an_state_e     next_state;
    tech_e         tech;
    tech_e         next_tech;
    logic          an_en;
    logic [15:0]   adv;
    logic [15:0]   lpa;
    logic          partner_negotiation_capable;
    logic          pd_fault;
    logic          no_signal;
    logic [PW-1:0] pd_cnt;
    logic [15:0]   rd_mux;
    flp_if         burst ();

    // ------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------
    function automatic tech_e resolve(input logic [15:0] a,
                                      input logic [15:0] b);
        logic [15:0] c;
        c = a & b;
        // The T4 ability is never tested here, so it can never win.
        if (c[ABIL_100FD]) begin
            return TECH_100FD;
        end else if (c[ABIL_100HD]) begin
            return TECH_100HD;
        end else if (c[ABIL_10FD]) begin
            return TECH_10FD;
        end else if (c[ABIL_10HD]) begin
            return TECH_10HD;
        end
        return TECH_NONE;
    endfunction

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire wr_ctrl  = reg_wr_in && (reg_addr_in == REG_CTRL);
    wire wr_adv   = reg_wr_in && (reg_addr_in == REG_ADV);
    wire rd_exp   = reg_rd_in && (reg_addr_in == REG_EXP);
    wire restart  = wr_ctrl && reg_wdata_in[CTRL_RESTART];
    wire detect   = (state == ST_DETECT);
    wire multi    = (rx_flp_in && (rx_nlp_in || rx_idle100_in))
                    || (rx_nlp_in && rx_idle100_in);
    wire sig_now  = rx_flp_in || rx_nlp_in || rx_idle100_in;
    wire word_ok  = detect && rx_flp_in && rx_word_valid_in && !multi;
    wire pd_only  = !rx_flp_in && !multi && (rx_nlp_in || rx_idle100_in);
    wire pd_run   = detect && pd_only;
    wire pd_done  = pd_run && (pd_cnt == PW'(PD_HOLD - 1));
    wire [15:0] pd_lpa = rx_nlp_in ? 16'(16'h0001 << ABIL_10HD)
                                   : 16'(16'h0001 << ABIL_100HD);
    wire [15:0] new_lpa = word_ok ? rx_word_in : pd_lpa;
    wire tech_e cand    = resolve(adv, new_lpa);
    wire rfault = lpa[ABIL_RFAULT];

    // ------------------------------------------------------------------
    // Negotiation state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (an_en) begin
                    next_state = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (multi) begin
                    next_state = ST_FAULT;
                end else if (word_ok || pd_done) begin
                    next_state = ST_COMPLETE;
                end
            end
            ST_COMPLETE: begin
                if (multi) begin
                    next_state = ST_FAULT;
                end else if (no_signal) begin
                    next_state = ST_DETECT;
                end
            end
            ST_FAULT: begin
                if (!multi) begin
                    next_state = ST_DETECT;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!an_en || link_fail_in || restart) begin
            next_state = ST_IDLE;
        end
    end

    always_comb begin
        next_tech = TECH_NONE;
        if (next_state == ST_COMPLETE) begin
            next_tech = (state == ST_COMPLETE) ? tech : cand;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            tech  <= TECH_NONE;
        end else begin
            state <= next_state;
            tech  <= next_tech;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pd_cnt <= '0;
        end else begin
            pd_cnt <= (pd_run && !pd_done) ? PW'(pd_cnt + 1'b1) : '0;
        end
    end

    // ------------------------------------------------------------------
    // Partner data and status bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lpa                         <= '0;
            partner_negotiation_capable <= 1'b0;
            pd_fault                    <= 1'b0;
            no_signal                   <= 1'b0;
        end else begin
            if (word_ok) begin
                lpa                         <= rx_word_in;
                partner_negotiation_capable <= 1'b1;
            end else if (pd_done) begin
                lpa                         <= pd_lpa;
                partner_negotiation_capable <= 1'b0;
            end
            if (rd_exp) begin
                pd_fault <= 1'b0;
            end
            if (multi && (detect || state == ST_COMPLETE)) begin
                pd_fault <= 1'b1;
            end
            no_signal <= !sig_now;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            an_en <= AN_EN_RESET;
            adv   <= ADV_RESET;
        end else begin
            if (wr_ctrl) begin
                an_en <= reg_wdata_in[CTRL_AN_EN];
            end
            if (wr_adv) begin
                adv <= reg_wdata_in;
            end
            if (local_fault_in) begin
                adv[ABIL_RFAULT] <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        case (reg_addr_in)
            REG_CTRL:  rd_mux[CTRL_AN_EN] = an_en;
            REG_STAT: begin
                rd_mux[STAT_COMPLETE] = an_complete_out;
                rd_mux[STAT_RFAULT]   = rfault;
            end
            REG_ADV:   rd_mux = adv;
            REG_LPA:   rd_mux = lpa;
            REG_EXP: begin
                rd_mux[EXP_LP_CAPABLE] = partner_negotiation_capable;
                rd_mux[EXP_PD_FAULT]   = pd_fault;
            end
            REG_QSTAT: begin
                rd_mux[QS_COMPLETE]  = an_complete_out;
                rd_mux[QS_NO_SIGNAL] = no_signal;
                rd_mux[QS_RFAULT]    = rfault;
            end
            REG_VSTAT: rd_mux[VS_RFAULT] = rfault;
            default:   rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Burst sender and outputs
    // ------------------------------------------------------------------
    assign burst.word     = adv;
    assign burst.flp_mode = detect;

    flp_burst_tx #(
        .SLOT_LEN (SLOT_LEN),
        .GAP_LEN  (GAP_LEN)
    ) u_burst (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .link    (burst)
    );

    assign link_pulse_out  = burst.pulse;
    assign flp_mode_out    = detect;
    assign an_complete_out = (state == ST_COMPLETE);
    assign en_100tx_out    = (tech == TECH_100FD) || (tech == TECH_100HD);
    assign en_10t_out      = (tech == TECH_10FD) || (tech == TECH_10HD);
    assign full_duplex_out = (tech == TECH_100FD) || (tech == TECH_10FD);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_fail_seen;
        link_fail_in && an_en;
    endsequence

    sequence s_back_to_detect;
        state == ST_IDLE ##1 state == ST_DETECT;
    endsequence

    AST_RESTART: assert property (
        s_fail_seen ##1 !link_fail_in && !restart && an_en
        |-> s_back_to_detect)
        else $error("Link failure did not restart negotiation.");

    AST_FLP_WHEN_NEG: assert property (
        (detect |-> flp_mode_out) and (!detect |=> !burst.active))
        else $error("Bursts not sent while negotiating.");

    AST_STORE_PARTNER: assert property (
        word_ok && !link_fail_in |=> lpa == $past(rx_word_in)
        && partner_negotiation_capable)
        else $error("Partner word not stored.");

    AST_RESOLVE_100FD: assert property (
        an_complete_out && adv[ABIL_100FD] && lpa[ABIL_100FD]
        |-> en_100tx_out && full_duplex_out && !en_10t_out)
        else $error("Top priority mode not chosen.");

    AST_COMPLETE_READ: assert property (
        reg_rd_in && reg_addr_in == REG_STAT && an_complete_out
        |=> reg_rdata_out[STAT_COMPLETE])
        else $error("Complete bit not visible.");

    AST_ONE_TECH: assert property (
        !(en_100tx_out && en_10t_out)
        && (an_complete_out || (!en_100tx_out && !en_10t_out)))
        else $error("More than one technology enabled.");

    AST_PD_RESULT: assert property (
        $rose(an_complete_out) && !partner_negotiation_capable
        |-> lpa[ABIL_10HD] != lpa[ABIL_100HD])
        else $error("Parallel detection left wrong partner bits.");

    AST_NO_SIGNAL: assert property (
        no_signal && !sig_now |=> !an_complete_out && tech == TECH_NONE)
        else $error("Completion held without signal.");

    AST_PD_FAULT: assert property (
        multi && detect |=> pd_fault && !en_100tx_out && !en_10t_out)
        else $error("Parallel detection fault not flagged.");

    AST_REMOTE_FAULT: assert property (
        reg_rd_in && reg_addr_in == REG_QSTAT && rfault
        |=> reg_rdata_out[QS_RFAULT])
        else $error("Remote fault not reported.");

    AST_LOCAL_FAULT: assert property (
        local_fault_in |=> adv[ABIL_RFAULT] && burst.word[ABIL_RFAULT])
        else $error("Local fault not advertised.");
endmodule
`default_nettype wire

// ==== pkg/link_autoneg_pkg.sv ====
// Constants, types and register map of the link negotiation block.
`default_nettype none
package link_autoneg_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_NS       = 62500;
    localparam int PD_HOLD_NS    = 10000000;
    localparam int SLOT_CYC      = SLOT_NS / CLK_PERIOD_NS;
    localparam int PD_HOLD_CYC   = (PD_HOLD_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int BURST_SLOTS   = 33;
    localparam int GAP_SLOTS     = 256;

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_STAT  = 5'h01;
    localparam logic [4:0] REG_ADV   = 5'h04;
    localparam logic [4:0] REG_LPA   = 5'h05;
    localparam logic [4:0] REG_EXP   = 5'h06;
    localparam logic [4:0] REG_QSTAT = 5'h11;
    localparam logic [4:0] REG_VSTAT = 5'h13;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_RESTART   = 9;
    localparam int CTRL_AN_EN     = 12;
    localparam int STAT_RFAULT    = 4;
    localparam int STAT_COMPLETE  = 5;
    localparam int ABIL_10HD      = 5;
    localparam int ABIL_10FD      = 6;
    localparam int ABIL_100HD     = 7;
    localparam int ABIL_100FD     = 8;
    localparam int ABIL_RFAULT    = 13;
    localparam int EXP_LP_CAPABLE = 0;
    localparam int EXP_PD_FAULT   = 4;
    localparam int QS_RFAULT      = 1;
    localparam int QS_NO_SIGNAL   = 3;
    localparam int QS_COMPLETE    = 4;
    localparam int VS_RFAULT      = 13;

    localparam logic [15:0] ADV_RESET   = 16'h01E1;
    localparam logic        AN_EN_RESET = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DETECT,
        ST_COMPLETE,
        ST_FAULT
    } an_state_e;

    typedef enum logic [2:0] {
        TECH_NONE,
        TECH_10HD,
        TECH_10FD,
        TECH_100HD,
        TECH_100FD
    } tech_e;

endpackage
`default_nettype wire

// ==== pkg/flp_if.sv ====
// Carrier between the negotiation core and its pulse burst sender.
`timescale 1ns/1ps
`default_nettype none
interface flp_if;
    logic [15:0] word;
    logic        flp_mode;
    logic        pulse;
    logic        active;

    modport src (output word, output flp_mode, input pulse, input active);
    modport tx  (input word, input flp_mode, output pulse, output active);
endinterface
`default_nettype wire

// ==== core/flp_burst_tx.sv ====
// Pulse burst sender: fast pulse bursts or single idle pulses.
`timescale 1ns/1ps
`default_nettype none
module flp_burst_tx
    import link_autoneg_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYC,
    parameter int GAP_LEN  = GAP_SLOTS
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    flp_if.tx         link
);
    localparam int DW = $clog2(SLOT_LEN + 1);
    localparam int SW = $clog2(GAP_LEN + 1);

    logic [DW-1:0] div_cnt;
    logic [SW-1:0] slot_idx;
    logic [15:0]   shreg;
    logic          pulse;
    logic          active;

    // ------------------------------------------------------------------
    // Slot timing
    // ------------------------------------------------------------------
    wire slot_en   = (div_cnt == DW'(SLOT_LEN - 1));
    wire last_slot = (slot_idx == SW'(GAP_LEN - 1));
    wire in_burst  = (slot_idx < SW'(BURST_SLOTS));
    wire data_slot = in_burst && slot_idx[0];
    wire first     = (slot_idx == '0);
    // Even slots carry clock pulses, odd slots a pulse only for a one bit.
    wire fire      = slot_en && (link.flp_mode ?
                     (in_burst && (!slot_idx[0] || shreg[0])) : first);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt  <= '0;
            slot_idx <= '0;
        end else begin
            div_cnt  <= slot_en ? '0 : DW'(div_cnt + 1'b1);
            if (slot_en) begin
                slot_idx <= last_slot ? '0 : SW'(slot_idx + 1'b1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Word shifting, least significant bit first
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shreg  <= '0;
            pulse  <= 1'b0;
            active <= 1'b0;
        end else begin
            if (slot_en && first) begin
                shreg <= link.word;
            end else if (slot_en && data_slot) begin
                shreg <= {1'b0, shreg[15:1]};
            end
            pulse  <= fire;
            active <= link.flp_mode && in_burst;
        end
    end

    assign link.pulse  = pulse;
    assign link.active = active;

    AST_WORD_LOAD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        slot_en && first |=> shreg == $past(link.word))
        else $error("Burst word not taken from advertisement.");

    AST_NLP_SINGLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        slot_en && !first && !link.flp_mode |=> !pulse)
        else $error("Extra pulse outside negotiation.");
endmodule
`default_nettype wire

// ==== verif/link_partner_model.sv ====
// Behavioural remote link partner driving the receive indications.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    input  wire logic        clk_in,
    input  wire logic [2:0]  mode_in,
    input  wire logic [15:0] word_in,
    output logic             rx_flp_out,
    output logic             rx_word_valid_out,
    output logic [15:0]      rx_word_out,
    output logic             rx_nlp_out,
    output logic             rx_idle100_out
);
    // ------------------------------------------------------------------
    // Mode 0 silent, 1 bursts, 2 idle pulses, 3 scrambled idles, 4 mixed
    // ------------------------------------------------------------------
    logic [1:0] cnt = 2'h0;
    always @(posedge clk_in) begin
        cnt <= cnt + 2'h1;
    end
    assign rx_flp_out        = (mode_in == 3'h1);
    assign rx_word_valid_out = rx_flp_out && (cnt == 2'h3);
    // Word lines show the inverse between words, so stale data cannot pass.
    assign rx_word_out    = rx_word_valid_out ? word_in : ~word_in;
    assign rx_nlp_out     = (mode_in == 3'h2) || (mode_in == 3'h4);
    assign rx_idle100_out = (mode_in == 3'h3) || (mode_in == 3'h4);
endmodule
`default_nettype wire

// ==== verif/link_autoneg_tb.sv ====
// Self-checking testbench of the link negotiation block.
`timescale 1ns/1ps
`default_nettype none
module link_autoneg_tb
    import link_autoneg_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk_in = 1'b0;
    logic        rstn_in;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [2:0]  mode;
    logic [15:0] pword;
    logic        flp;
    logic        wv;
    logic [15:0] rword;
    logic        nlp;
    logic        idle;
    logic        lfail;
    logic        lfault;
    logic        cmpl;
    logic        e100;
    logic        e10;
    logic        fd;
    logic        flpm;
    logic        lpulse;
    logic [15:0] v;
    int          error_cnt = 0;
    int          tests_run = 0;
    wire  [15:0] outs = {12'h0, cmpl, e100, e10, fd};
    logic [15:0] adv_t [7] = '{16'h01E1, 16'h01E1, 16'h01E1, 16'h01E1,
                               16'h00A1, 16'h0021, 16'h01E1};
    logic [15:0] lp_t  [7] = '{16'h01E1, 16'h0081, 16'h0061, 16'h0021,
                               16'h01E1, 16'h0101, 16'h2021};
    logic [15:0] exp_t [7] = '{16'hD, 16'hC, 16'hB, 16'hA,
                               16'hC, 16'h8, 16'hA};

    always #5 clk_in = ~clk_in;

    link_autoneg #(.SLOT_LEN(4), .GAP_LEN(40), .PD_HOLD(8)) dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .rx_flp_in(flp), .rx_word_valid_in(wv),
        .rx_word_in(rword), .rx_nlp_in(nlp), .rx_idle100_in(idle),
        .link_fail_in(lfail), .local_fault_in(lfault),
        .link_pulse_out(lpulse), .flp_mode_out(flpm), .an_complete_out(cmpl),
        .en_100tx_out(e100), .en_10t_out(e10), .full_duplex_out(fd));

    link_partner_model partner (
        .clk_in(clk_in), .mode_in(mode), .word_in(pword),
        .rx_flp_out(flp), .rx_word_valid_out(wv), .rx_word_out(rword),
        .rx_nlp_out(nlp), .rx_idle100_out(idle));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Waits are bounded so a dead machine ends the run instead of hanging.
    task automatic wait_cmpl(input logic lvl);
        int n;
        for (n = 0; n < 300 && cmpl !== lvl; n++) begin
            @(posedge clk_in);
            #1;
        end
        if (cmpl !== lvl) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    // One window spans exactly one frame of the shortened slot timing.
    task automatic count_pulses(output logic [15:0] n);
        n = '0;
        repeat (160) begin
            @(posedge clk_in);
            #1 n = n + 16'(lpulse);
        end
    endtask

    task automatic neg(input logic [15:0] a, input logic [15:0] w,
                       input logic [2:0] m);
        @(posedge clk_in);
        mode <= 3'h0;
        wreg(REG_ADV, a);
        wreg(REG_CTRL, 16'h1200);
        mode  <= m;
        pword <= w;
        wait_cmpl(1'b1);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        {addr, wdata, wr, rd, mode, pword, lfail, lfault} = '0;
        rstn_in = 1'b0;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        rreg(REG_ADV, v);
        chk(v, ADV_RESET);
        rreg(REG_CTRL, v);
        chk(v, 16'h1000);
        rreg(5'h02, v);
        chk(v, 16'h0000);
        chk({15'h0, flpm}, 16'h1);
        count_pulses(v);
        chk(v, 16'((BURST_SLOTS + 1) / 2 + $countones(ADV_RESET)));
        for (int i = 0; i < 7; i++) begin
            neg(adv_t[i], lp_t[i], 3'h1);
            chk(outs, exp_t[i]);
            rreg(REG_LPA, v);
            chk(v, lp_t[i]);
            rreg(REG_EXP, v);
            chk({15'h0, v[EXP_LP_CAPABLE]}, 16'h1);
            rreg(REG_STAT, v);
            chk({14'h0, v[5:4]}, {14'h0, 1'b1, lp_t[i][13]});
            rreg(REG_QSTAT, v);
            chk({14'h0, v[4], v[1]}, {14'h0, 1'b1, lp_t[i][13]});
            rreg(REG_VSTAT, v);
            chk({15'h0, v[13]}, {15'h0, lp_t[i][13]});
        end
        neg(16'h01E1, 16'h0, 3'h2);
        chk(outs, 16'hA);
        rreg(REG_LPA, v);
        chk(v & 16'h00A0, 16'h0020);
        rreg(REG_EXP, v);
        chk({15'h0, v[EXP_LP_CAPABLE]}, 16'h0);
        neg(16'h01E1, 16'h0, 3'h3);
        chk(outs, 16'hC);
        rreg(REG_LPA, v);
        chk(v & 16'h00A0, 16'h0080);
        @(posedge clk_in);
        mode <= 3'h0;
        repeat (4) @(posedge clk_in);
        #1 chk(outs, 16'h0);
        rreg(REG_QSTAT, v);
        chk({15'h0, v[QS_NO_SIGNAL]}, 16'h1);
        @(posedge clk_in);
        mode <= 3'h4;
        repeat (4) @(posedge clk_in);
        #1 chk(outs, 16'h0);
        rreg(REG_EXP, v);
        chk({15'h0, v[EXP_PD_FAULT]}, 16'h1);
        rreg(REG_QSTAT, v);
        chk({15'h0, v[QS_COMPLETE]}, 16'h0);
        @(posedge clk_in);
        lfault <= 1'b1;
        rreg(REG_ADV, v);
        chk({15'h0, v[ABIL_RFAULT]}, 16'h1);
        @(posedge clk_in);
        lfault <= 1'b0;
        neg(16'h01E1, 16'h01E1, 3'h1);
        rreg(REG_ADV, v);
        chk(v, 16'h01E1);
        @(posedge clk_in);
        lfail <= 1'b1;
        @(posedge clk_in);
        lfail <= 1'b0;
        #1 chk(outs, 16'h0);
        wait_cmpl(1'b1);
        wreg(REG_CTRL, 16'h0000);
        @(posedge clk_in);
        #1 chk(outs, 16'h0);
        wreg(REG_CTRL, 16'h1000);
        wait_cmpl(1'b1);
        chk(outs, 16'hD);
        count_pulses(v);
        chk(v, 16'h0001);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 chk({11'h0, flpm, outs[3:0]}, 16'h0);
        @(posedge clk_in);
        rstn_in <= 1'b1;
        mode    <= 3'h0;
        rreg(REG_LPA, v);
        chk(v, 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
